// ==== lfs_pkg.sv ====
// Constants, reset values and state codes for the LED driver fault sequencer
// Summary of operation
// R01: Overvoltage seen: gate low, dimming gate high, fault flag pulled low.
// R02: Overvoltage cleared with hysteresis: switching, dimming gate and flag restored.
// R03: Fault flag pulls low on overvoltage, string short or overtemperature.
// R04: Outside short latching and counting, fault flag releases when cause ends.
// R05: Overtemperature holds switching gate low and dimming gate high.
// R06: Transistors return only after overtemperature clears; overload cycles output.
// R07: Boost short held one microsecond starts an 8192 oscillator-cycle hiccup.
// R08: During hiccup: gate low, dimming gate high, amplifier cut, flag low.
// R09: After hiccup retry; flag stays latched until 20 us without short.
// R10: Buck-boost short keeps regulating; short means low sense headroom.
// R11: Buck-boost short counts up; flag after 8192 consecutive short cycles.
// R12: Headroom restored counts down; flag clears after 8192 clear cycles.
// R13: Current-sense trip ends each on-pulse for peak current-mode control.
// R14: Current-sense trip ignored for 50 ns blanking at on-pulse start.
// R15: Dimming input low: amplifier cut, dimming gate high, switching off.
// R16: Hiccup and buck-boost counts use oscillator ticks; short times use clk.
package lfs_pkg;
    // ==========================================================
    // Widths
    localparam int CNT_W  = 14;
    localparam int SYNC_W = 8;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BLANK_NS      = 50;
    localparam int SHORT_QUAL_NS = 1000;
    localparam int RETRY_NS      = 20000;
    localparam logic [CNT_W-1:0] BLANK_CYC =
        CNT_W'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SHORT_QUAL_CYC =
        CNT_W'((SHORT_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RETRY_CYC =
        CNT_W'((RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] HICCUP_TICKS = 14'h2000;
    localparam logic [CNT_W-1:0] BB_TICKS     = 14'h2000;

    // ==========================================================
    // Reset values
    localparam logic RST_GATE     = 1'h0;
    localparam logic RST_DIM_N    = 1'h1;
    localparam logic RST_COMP     = 1'h0;
    localparam logic RST_FAULT_OE = 1'h0;
    localparam logic RST_LATCH    = 1'h0;
    localparam logic [CNT_W-1:0] RST_CNT = 14'h0000;
    localparam logic [SYNC_W-1:0] RST_SYNC = 8'h00;

    // ==========================================================
    // Boost short sequencer states
    typedef enum logic [3:0] {
        ST_RUN    = 4'b0001,
        ST_QUAL   = 4'b0010,
        ST_HICCUP = 4'b0100,
        ST_RETRY  = 4'b1000
    } lfs_state_e;
endpackage

// ==== lfs_qual_if.sv ====
// Handshake bundle between the sequencer and one qualification timer
`timescale 1ns/1ps
interface lfs_qual_if;
    logic cond;
    logic tick;
    logic done;
    modport tmr (input cond, input tick, output done);
    modport ctl (output cond, output tick, input done);
endinterface

// ==== lfs_sync.sv ====
// Two-stage synchroniser for the comparator and pin inputs
`timescale 1ns/1ps
module lfs_sync (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Data
    input  wire logic [lfs_pkg::SYNC_W-1:0] d,
    output logic      [lfs_pkg::SYNC_W-1:0] q
);
    import lfs_pkg::*;

    logic [SYNC_W-1:0] meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= RST_SYNC;
            q    <= RST_SYNC;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ==== lfs_qual_timer.sv ====
// Consecutive-condition timer: done after LIMIT ticks of an unbroken condition
`timescale 1ns/1ps
module lfs_qual_timer #(
    parameter logic [lfs_pkg::CNT_W-1:0] LIMIT = 14'h0001
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Condition and result
    lfs_qual_if.tmr   q
);
    import lfs_pkg::*;

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;

    always_comb begin
        next_cnt = cnt;
        if (!q.cond) begin
            next_cnt = RST_CNT;
        end else if (q.tick && cnt != LIMIT) begin
            next_cnt = cnt + 14'h0001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= RST_CNT;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign q.done = q.cond && (cnt == LIMIT);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    cond_break_a: assert property (!q.cond |=> cnt == RST_CNT) // R16
        else $error("timer did not restart when condition broke");
endmodule

// ==== lfs_fault_seq.sv ====
// Top of the LED driver fault and protection sequencer
`timescale 1ns/1ps
module lfs_fault_seq #(
    parameter logic [lfs_pkg::CNT_W-1:0] HICCUP_LEN = lfs_pkg::HICCUP_TICKS,
    parameter logic [lfs_pkg::CNT_W-1:0] BB_LEN     = lfs_pkg::BB_TICKS
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Switching oscillator and configuration
    input  wire logic osc_in,
    input  wire logic boost_mode,
    // Comparator flags and dimming input
    input  wire logic overvoltage_sense,
    input  wire logic over_temp,
    input  wire logic boost_short,
    input  wire logic bb_short,
    input  wire logic cs_trip,
    input  wire logic dim_input,
    // Gate drives
    output logic      switch_gate_drive,
    output logic      dim_gate_drive_n,
    output logic      comp_connect,
    // Open-drain fault flag
    output logic      fault_n_o,
    output logic      fault_n_oe
);
    import lfs_pkg::*;

    // ==========================================================
    // Input synchronisation
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] syn;
    logic osc_s;
    logic boost_s;
    logic ov_s;
    logic ot_s;
    logic bs_s;
    logic bb_s;
    logic cs_s;
    logic dim_s;

    assign raw = {osc_in, boost_mode, overvoltage_sense, over_temp,
                  boost_short, bb_short, cs_trip, dim_input};

    lfs_sync u_sync (
        .clk (clk),
        .rst (rst),
        .d   (raw),
        .q   (syn)
    );

    assign osc_s   = syn[7];
    assign boost_s = syn[6];
    assign ov_s    = syn[5];
    assign ot_s    = syn[4];
    assign bs_s    = syn[3];
    assign bb_s    = syn[2];
    assign cs_s    = syn[1];
    assign dim_s   = syn[0];

    // ==========================================================
    // State
    lfs_state_e state;
    lfs_state_e next_state;
    logic       boost_latch;
    logic       next_boost_latch;
    logic       bb_fault;
    logic       next_bb_fault;
    logic       osc_d;
    logic       osc_tick;
    logic       boost_short_act;
    logic       bb_short_act;
    logic       sw_en;
    logic       next_gate;
    logic       next_dim_n;
    logic       next_comp;
    logic       next_fault_oe;

    assign osc_tick        = osc_s && !osc_d;
    assign boost_short_act = boost_s && bs_s;
    // R10 short counted only
    // Buck-boost short never stops switching; only the counter watches it
    assign bb_short_act    = !boost_s && bb_s;

    // ==========================================================
    // Qualification timers
    lfs_qual_if blk_q ();
    lfs_qual_if sq_q ();
    lfs_qual_if hic_q ();
    lfs_qual_if ret_q ();
    lfs_qual_if bb_q ();

    assign blk_q.cond = switch_gate_drive;
    assign blk_q.tick = 1'b1;
    assign sq_q.cond  = (state == ST_QUAL) && boost_short_act;
    assign sq_q.tick  = 1'b1;
    // R16 oscillator tick counts
    assign hic_q.cond = (state == ST_HICCUP);
    assign hic_q.tick = osc_tick;
    assign ret_q.cond = (state == ST_RETRY) && !boost_short_act;
    assign ret_q.tick = 1'b1;
    assign bb_q.cond  = (bb_short_act != bb_fault);
    assign bb_q.tick  = osc_tick;

    lfs_qual_timer #(.LIMIT(BLANK_CYC)) u_blank (
        .clk (clk),
        .rst (rst),
        .q   (blk_q)
    );

    lfs_qual_timer #(.LIMIT(SHORT_QUAL_CYC)) u_short (
        .clk (clk),
        .rst (rst),
        .q   (sq_q)
    );

    lfs_qual_timer #(.LIMIT(HICCUP_LEN)) u_hiccup (
        .clk (clk),
        .rst (rst),
        .q   (hic_q)
    );

    lfs_qual_timer #(.LIMIT(RETRY_CYC)) u_retry (
        .clk (clk),
        .rst (rst),
        .q   (ret_q)
    );

    lfs_qual_timer #(.LIMIT(BB_LEN)) u_bb (
        .clk (clk),
        .rst (rst),
        .q   (bb_q)
    );

    // ==========================================================
    // Boost short sequencer and buck-boost flag
    always_comb begin
        next_state       = state;
        next_boost_latch = boost_latch;
        next_bb_fault    = bb_fault;
        case (state)
            ST_RUN: begin
                if (boost_short_act) begin
                    next_state = ST_QUAL;
                end
            end
            ST_QUAL: begin
                // R07 one-microsecond qualification
                if (sq_q.done) begin
                    next_state       = ST_HICCUP;
                    next_boost_latch = 1'b1;
                end else if (!boost_short_act) begin
                    next_state = boost_latch ? ST_RETRY : ST_RUN;
                end
            end
            ST_HICCUP: begin
                // R09 retry once the hiccup time is over
                if (hic_q.done) begin
                    next_state = ST_RETRY;
                end
            end
            ST_RETRY: begin
                // R09 latch clears only after a clean retry window
                if (boost_short_act) begin
                    next_state = ST_QUAL;
                end else if (ret_q.done) begin
                    next_state       = ST_RUN;
                    next_boost_latch = 1'b0;
                end
            end
            default: begin
                next_state       = ST_RUN;
                next_boost_latch = RST_LATCH;
            end
        endcase
        // R11 R12 flag flips after a full run of the opposite condition
        if (bb_q.done) begin
            next_bb_fault = !bb_fault;
        end
    end

    // ==========================================================
    // Gate and flag outputs
    always_comb begin
        // R01 R05 R08 R15 conditions that stop switching
        sw_en = dim_s && !ov_s && !ot_s && (state != ST_HICCUP);
        next_gate = switch_gate_drive;
        if (!sw_en) begin
            next_gate = 1'b0;
        end else if (osc_tick) begin
            next_gate = 1'b1;
        // R13 R14 trip ends the pulse only after blanking
        end else if (switch_gate_drive && blk_q.done && cs_s) begin
            next_gate = 1'b0;
        end
        // R02 R06 dimming gate follows the same enables
        next_dim_n = !sw_en;
        // R08 R15 amplifier cut while dimmed or in hiccup
        next_comp = dim_s && (state != ST_HICCUP);
        // R03 R04 fault pulls low only while a cause stands
        next_fault_oe = ov_s || ot_s || boost_latch || bb_fault;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state             <= ST_RUN;
            boost_latch       <= RST_LATCH;
            bb_fault          <= RST_LATCH;
            osc_d             <= RST_LATCH;
            switch_gate_drive <= RST_GATE;
            dim_gate_drive_n  <= RST_DIM_N;
            comp_connect      <= RST_COMP;
            fault_n_oe        <= RST_FAULT_OE;
        end else begin
            state             <= next_state;
            boost_latch       <= next_boost_latch;
            bb_fault          <= next_bb_fault;
            osc_d             <= osc_s;
            switch_gate_drive <= next_gate;
            dim_gate_drive_n  <= next_dim_n;
            comp_connect      <= next_comp;
            fault_n_oe        <= next_fault_oe;
        end
    end

    // Open drain: only ever drives low
    assign fault_n_o = 1'b0;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence ot_cleared_s;
        ot_s ##1 (!ot_s && !ov_s && dim_s && state != ST_HICCUP);
    endsequence

    sequence hiccup_entry_s;
        (state == ST_QUAL) && sq_q.done;
    endsequence

    sequence hiccup_exit_s;
        (state == ST_HICCUP) && hic_q.done;
    endsequence

    ovp_shutdown_a: assert property ( // R01
        ov_s |=> !switch_gate_drive && dim_gate_drive_n && fault_n_oe)
        else $error("overvoltage did not shut down outputs");
    ovp_release_a: assert property ( // R02
        $fell(ov_s) && !ot_s && dim_s && state == ST_RUN && !bb_fault && !boost_latch
        |=> !dim_gate_drive_n && !fault_n_oe)
        else $error("outputs not restored after overvoltage");
    fault_causes_a: assert property ((ov_s || ot_s || bb_fault) |=> fault_n_oe) // R03
        else $error("fault flag not pulled low");
    fault_release_a: assert property ( // R04
        !ov_s && !ot_s && !bb_fault && !boost_latch |=> !fault_n_oe)
        else $error("fault flag held without cause");
    ot_hold_a: assert property (ot_s |=> !switch_gate_drive && dim_gate_drive_n) // R05
        else $error("overtemperature did not hold gates off");
    ot_recover_a: assert property (ot_cleared_s |=> !dim_gate_drive_n) // R06
        else $error("dimming gate not restored after cooling");
    hiccup_start_a: assert property ( // R07
        hiccup_entry_s |=> state == ST_HICCUP && boost_latch ##1 fault_n_oe)
        else $error("qualified short did not start hiccup");
    hiccup_hold_a: assert property ( // R08
        state == ST_HICCUP |=> !switch_gate_drive && dim_gate_drive_n
                              && !comp_connect && fault_n_oe)
        else $error("hiccup outputs wrong");
    retry_latch_a: assert property ( // R09
        state == ST_RETRY && !ret_q.done |=> boost_latch ##1 fault_n_oe)
        else $error("fault latch lost during retry");
    bb_regulate_a: assert property ( // R10
        bb_short_act && sw_en && !ov_s |=> !dim_gate_drive_n)
        else $error("buck-boost short stopped regulation");
    bb_count_a: assert property ($rose(bb_fault) |-> $past(bb_short_act)) // R11
        else $error("buck-boost flag set without short");
    bb_clear_a: assert property ($fell(bb_fault) |-> !$past(bb_short_act)) // R12
        else $error("buck-boost flag cleared during short");
    peak_end_a: assert property ( // R13
        switch_gate_drive && blk_q.done && cs_s && !osc_tick |=> !switch_gate_drive)
        else $error("current trip did not end pulse");
    blank_hold_a: assert property ( // R14
        switch_gate_drive && !blk_q.done && sw_en |=> switch_gate_drive)
        else $error("pulse ended inside blanking");
    dim_off_a: assert property ( // R15
        !dim_s |=> !switch_gate_drive && dim_gate_drive_n && !comp_connect)
        else $error("dimming low did not stop outputs");

    // Retry and mode sequencing, pulse start and amplifier connection
    retry_start_a: assert property (hiccup_exit_s |=> state == ST_RETRY && boost_latch) // R09
        else $error("hiccup end did not start retry");
    retry_release_a: assert property ( // R09
        state == ST_RETRY && ret_q.done |=> state == ST_RUN && !boost_latch)
        else $error("clean retry did not release latch");
    latch_fault_a: assert property (boost_latch |=> fault_n_oe) // R09
        else $error("latched short did not hold fault flag");
    qual_abort_a: assert property ( // R07
        state == ST_QUAL && !sq_q.done |=> state != ST_HICCUP)
        else $error("hiccup started before qualification");
    bb_no_hiccup_a: assert property (!boost_s && state == ST_RUN |=> state == ST_RUN) // R10
        else $error("buck-boost mode left run state");
    gate_start_a: assert property (osc_tick && sw_en |=> switch_gate_drive) // R02
        else $error("oscillator tick did not start pulse");
    comp_run_a: assert property (dim_s && state != ST_HICCUP |=> comp_connect) // R15
        else $error("amplifier not connected while running");
endmodule

// ==== lfs_partner.sv ====
// Behavioural switching oscillator and switch current-sense comparator
`timescale 1ns/1ps
module lfs_partner (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Gate drive and trip point in clk cycles of on-time
    input  wire logic       gate,
    input  wire logic [7:0] trip_at,
    // Oscillator and comparator outputs
    output logic            osc_in,
    output logic            cs_trip
);
    logic [7:0] div;
    logic [7:0] on_cnt;

    // ==========================================================
    // Oscillator runs free: period 40 clk
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div    <= 8'h00;
            osc_in <= 1'b0;
        end else if (div == 8'h13) begin
            div    <= 8'h00;
            osc_in <= ~osc_in;
        end else begin
            div <= div + 8'h01;
        end
    end

    // ==========================================================
    // Inductor current ramps while the gate is on
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            on_cnt <= 8'h00;
        end else if (gate) begin
            on_cnt <= on_cnt + 8'h01;
        end else begin
            on_cnt <= 8'h00;
        end
    end

    assign cs_trip = gate && (on_cnt >= trip_at);
endmodule

// ==== lfs_fault_seq_tb.sv ====
// Self-checking testbench for the fault sequencer
`timescale 1ns/1ps
module lfs_fault_seq_tb;
    logic       clk;
    logic       rst;
    logic       osc_in;
    logic       boost_mode;
    logic       ov;
    logic       ot;
    logic       boost_short;
    logic       bb_short;
    logic       cs_trip;
    logic       dim_input;
    logic       gate;
    logic       dim_n;
    logic       comp;
    logic       flt_o;
    logic       oe;
    logic [7:0] trip_at;
    int         bad_count;
    int         num_checks;

    lfs_fault_seq #(.HICCUP_LEN(14'h0010), .BB_LEN(14'h0010)) DUT (
        .clk(clk), .rst(rst), .osc_in(osc_in), .boost_mode(boost_mode),
        .overvoltage_sense(ov), .over_temp(ot), .boost_short(boost_short),
        .bb_short(bb_short), .cs_trip(cs_trip), .dim_input(dim_input),
        .switch_gate_drive(gate), .dim_gate_drive_n(dim_n), .comp_connect(comp),
        .fault_n_o(flt_o), .fault_n_oe(oe));

    lfs_partner far_side (
        .clk(clk), .rst(rst), .gate(gate), .trip_at(trip_at),
        .osc_in(osc_in), .cs_trip(cs_trip));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Cycles with the gate high over a window
    task automatic count_high(input int n, output int w);
        w = 0;
        repeat (n) begin
            @(negedge clk);
            if (gate === 1'b1) w++;
        end
    endtask

    task automatic wait_gate(input logic lvl);
        int i;
        for (i = 0; i < 200 && gate !== lvl; i++) @(negedge clk);
        if (gate !== lvl) begin
            bad_count++;
            $display("BAD t=%0t gate wait timed out", $time);
            results();
        end
    endtask

    task automatic t_peak();
        int w;
        trip_at = 8'h0c;
        wait_gate(1'b0);
        wait_gate(1'b1);
        w = 0;
        while (gate === 1'b1 && w < 50) begin
            @(negedge clk);
            w++;
        end
        check(16'(w >= 12 && w <= 16), 16'h0001); // trip ends pulse
        trip_at = 8'h01;
        wait_gate(1'b0);
        wait_gate(1'b1);
        w = 0;
        while (gate === 1'b1 && w < 50) begin
            @(negedge clk);
            w++;
        end
        check(16'(w >= 5 && w <= 8), 16'h0001); // blanking holds gate
        trip_at = 8'h0c;
        $display("test peak done");
    endtask

    task automatic t_ovp();
        ov = 1'b1;
        wait_cyc(4);
        check({gate, dim_n, oe, comp}, 16'h0007); // gate off flag on
        ov = 1'b0;
        wait_cyc(4);
        check({dim_n, oe}, 16'h0000); // flag released
        wait_gate(1'b1); // switching resumes
        $display("test ovp done");
    endtask

    task automatic t_thermal();
        int w;
        ot = 1'b1;
        wait_cyc(3);
        count_high(100, w);
        check(16'(w), 16'h0000); // gate held low
        check({dim_n, oe}, 16'h0003); // dimming off flag on
        ot = 1'b0;
        wait_cyc(4);
        check({dim_n, oe}, 16'h0000); // released on clear
        wait_gate(1'b1); // switching back
        $display("test thermal done");
    endtask

    task automatic t_dim();
        int w;
        dim_input = 1'b0;
        wait_cyc(3);
        count_high(80, w);
        check(16'(w), 16'h0000); // switching off
        check({dim_n, comp, oe}, 16'h0004); // amp cut, dimming gate high
        dim_input = 1'b1;
        wait_cyc(4);
        check({dim_n, comp}, 16'h0001); // restored
        $display("test dim done");
    endtask

    task automatic t_hiccup();
        int w;
        boost_mode  = 1'b1;
        boost_short = 1'b1;
        wait_cyc(50);
        boost_short = 1'b0;
        wait_cyc(4);
        check(oe, 1'b0); // brief short ignored
        boost_short = 1'b1;
        wait_cyc(120);
        boost_short = 1'b0;
        check({oe, comp, dim_n}, 16'h0005); // hiccup started
        count_high(200, w);
        check(16'(w), 16'h0000); // gate held low
        check({oe, comp, dim_n}, 16'h0005); // still in hiccup
        wait_cyc(500);
        count_high(300, w);
        check(16'(w > 0), 16'h0001); // retry switching
        check({oe, comp}, 16'h0003); // flag latched in retry
        wait_cyc(1500);
        check(oe, 1'b1); // latched inside window
        wait_cyc(300);
        check(oe, 1'b0); // released after clean retry
        $display("test hiccup done");
    endtask

    task automatic t_bb();
        int w;
        boost_mode  = 1'b0;
        boost_short = 1'b1;
        wait_cyc(150);
        check(oe, 1'b0); // boost short ignored here
        boost_short = 1'b0;
        bb_short = 1'b1;
        count_high(560, w);
        check(16'(w > 0), 16'h0001); // keeps regulating
        check(oe, 1'b0); // count not reached
        wait_cyc(200);
        check(oe, 1'b1); // flag after full count
        bb_short = 1'b0;
        wait_cyc(560);
        check(oe, 1'b1); // flag holds while counting down
        wait_cyc(200);
        check(oe, 1'b0); // flag released
        $display("test buck-boost done");
    endtask

    initial begin
        bad_count   = 0;
        num_checks  = 0;
        rst         = 1'b1;
        boost_mode  = 1'b1;
        ov          = 1'b0;
        ot          = 1'b0;
        boost_short = 1'b0;
        bb_short    = 1'b0;
        dim_input   = 1'b1;
        trip_at     = 8'h0c;
        wait_cyc(5);
        check({gate, dim_n, comp, oe, flt_o}, 16'h0008); // idle while reset is held
        rst = 1'b0;
        wait_cyc(4);
        $display("test reset done");
        t_peak();
        t_ovp();
        t_thermal();
        t_dim();
        t_hiccup();
        t_bb();
        results();
    end
endmodule
